// >>> hw/pcg_top.sv
// Peripheral clock gating: per-peripheral bus and kernel clock enables
// How it works
// [RULE1] Owner running: bus and kernel clocks on
// [RULE2] Owner sleeping: clocks follow low-power enable
// [RULE3] Owner halted, light system mode: bus on request
// [RULE4] Deep modes: bus also needs autonomous enable
// [RULE5] Halted: kernel on request from fast sources
// [RULE6] Halted: slow sources clocked without any request
// [RULE7] Autonomous: kernel on request from slow and multispeed sources
// [RULE8] Only serial peripherals raise kernel requests
// [RULE9] Unkept standby or halt makes debug unreachable
// [RULE10] Emulation keeps clock and power, mode unchanged
// [RULE11] Separate keep bits for standby, halt, sleep
// [RULE12] Line 7: wait-irq at 0, wait-event at 1
// [RULE13] Selector 6: core halt flags on 2, 1
// [RULE14] Selector 6: line 0 shows unclocked system halt
// [RULE15] Selector 0: line 0 shows system wake
// [RULE16] Line 0: app wake at 2, mcu at 1
// [RULE17] Clear allocation bit: no clock via that core
// [RULE18] Deep system modes filter out non-autonomous bus requests
// [RULE19] Every other combination gates both clocks off
`include "pcg_defines.svh"

module pcg_top import pcg_pkg::*; #(
  parameter int NUM_PERIPH = 4
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // Register port
  input  wire logic [`PCG_ADDR_W-1:0]   addr,
  input  wire logic [31:0]              wdata,
  input  wire logic                     wr_stb,
  input  wire logic                     rd_stb,
  output logic      [31:0]              rdata,
  // Processor and system state
  input  wire pcg_core_e                app_core_state,
  input  wire pcg_core_e                mcu_core_state,
  input  wire pcg_sys_e                 sys_mode,
  // Peripheral side
  input  wire logic [NUM_PERIPH-1:0]    bus_clk_req,
  input  wire logic [NUM_PERIPH-1:0]    ker_clk_req,
  output logic      [NUM_PERIPH-1:0]    bus_clk_en,
  output logic      [NUM_PERIPH-1:0]    ker_clk_en,
  // Debug and observation
  input  wire pcg_obs_in_s              obs_in,
  output pcg_hold_s                     dbg_hold,
  output logic      [7:0]               observation_port
);

  typedef struct packed {
    pcg_cfg_s [NUM_PERIPH-1:0] cfg;
    pcg_dbg_s                  dbg;
    logic [`PCG_SEL_W-1:0]     sel;
    logic [NUM_PERIPH-1:0]     bus_en;
    logic [NUM_PERIPH-1:0]     ker_en;
    logic [7:0]                obs;
    pcg_hold_s                 hold;
    logic [31:0]               rdata;
  } pcg_state_s;

  pcg_state_s              st_r;
  pcg_state_s              st_nxt;
  logic [NUM_PERIPH-1:0]   bus_on_app;
  logic [NUM_PERIPH-1:0]   bus_on_mcu;
  logic [NUM_PERIPH-1:0]   ker_on_app;
  logic [NUM_PERIPH-1:0]   ker_on_mcu;
  logic                    sys_halt;
  logic                    sys_standby;
  logic                    sys_unclocked;

  // One cell per peripheral and owner; a peripheral shared by both
  // processors is clocked whenever either owner grants it
  for (genvar g = 0; g < NUM_PERIPH; g++) begin : g_periph
    pcg_gate_cell u_app (
      .core_state  (app_core_state),
      .sys_mode    (sys_mode),
      .cfg         (st_r.cfg[g]),
      .alloc       (st_r.cfg[g].alloc_enable_bit_app),
      .bus_clk_req (bus_clk_req[g]),
      .ker_clk_req (ker_clk_req[g]),
      .bus_on      (bus_on_app[g]),
      .ker_on      (ker_on_app[g])
    );
    pcg_gate_cell u_mcu (
      .core_state  (mcu_core_state),
      .sys_mode    (sys_mode),
      .cfg         (st_r.cfg[g]),
      .alloc       (st_r.cfg[g].alloc_enable_bit_mcu),
      .bus_clk_req (bus_clk_req[g]),
      .ker_clk_req (ker_clk_req[g]),
      .bus_on      (bus_on_mcu[g]),
      .ker_on      (ker_on_mcu[g])
    );
  end

  assign sys_halt      = pcg_sys_halted(sys_mode);
  assign sys_standby   = (sys_mode == system_standby_level1);
  // A kept halt leaves the system clocked, so it is not reported as stopped
  assign sys_unclocked = sys_halt && !st_r.dbg.debug_keep_halt; // [RULE14]

  always_comb begin
    st_nxt       = st_r;
    st_nxt.rdata = 32'h0000_0000;

    // Register writes
    for (int i = 0; i < NUM_PERIPH; i++) begin
      if (wr_stb && addr == 8'(`PCG_ADDR_CFG0 + 4 * i)) begin
        st_nxt.cfg[i] = pcg_cfg_s'(wdata[`PCG_CFG_W-1:0]);
      end
    end
    if (wr_stb && addr == `PCG_ADDR_DBGCTL) begin
      st_nxt.dbg = pcg_dbg_s'(wdata[`PCG_DBG_W-1:0]); // [RULE11]
    end
    if (wr_stb && addr == `PCG_ADDR_OBSSEL) begin
      st_nxt.sel = wdata[`PCG_SEL_W-1:0];
    end

    // Register reads; unmapped addresses return zero
    if (rd_stb) begin
      for (int i = 0; i < NUM_PERIPH; i++) begin
        if (addr == 8'(`PCG_ADDR_CFG0 + 4 * i)) begin
          st_nxt.rdata = 32'(st_r.cfg[i]);
        end
      end
      case (addr)
        `PCG_ADDR_DBGCTL:   st_nxt.rdata = 32'(st_r.dbg);
        `PCG_ADDR_OBSSEL:   st_nxt.rdata = 32'(st_r.sel);
        `PCG_ADDR_CLKSTAT:  st_nxt.rdata = (32'(st_r.ker_en) << 8) | 32'(st_r.bus_en);
        `PCG_ADDR_MODESTAT: st_nxt.rdata = {24'h00_0000, st_r.hold.debug_reachable,
                                            sys_mode, mcu_core_state, app_core_state};
        default: begin
        end
      endcase
    end

    // Clock enables; emulation never changes them, the mode still acts
    st_nxt.bus_en = bus_on_app | bus_on_mcu; // [RULE10]
    st_nxt.ker_en = ker_on_app | ker_on_mcu;

    // Emulation holds
    st_nxt.hold.core_clk_hold =
      (st_r.dbg.debug_keep_sleep &&
       (app_core_state == core_sleep_state || mcu_core_state == core_sleep_state)) ||
      (st_r.dbg.debug_keep_halt &&
       (app_core_state == core_halted_state || mcu_core_state == core_halted_state)); // [RULE11]
    st_nxt.hold.sys_clk_hold  = sys_halt && st_r.dbg.debug_keep_halt; // [RULE10]
    st_nxt.hold.core_pwr_hold = sys_standby && st_r.dbg.debug_keep_standby; // [RULE10]
    st_nxt.hold.debug_reachable =
      !(sys_standby && !st_r.dbg.debug_keep_standby) && !sys_unclocked; // [RULE9]

    // Observation port
    st_nxt.obs = 8'h00;
    case (st_r.sel)
      `PCG_SEL_WAIT_IRQ: begin
        st_nxt.obs[7] = obs_in.core0_wait_irq_flag; // [RULE12]
        st_nxt.obs[0] = obs_in.sys_wake; // [RULE15]
      end
      `PCG_SEL_WAIT_EVENT: begin
        st_nxt.obs[7] = obs_in.core0_wait_event_flag; // [RULE12]
        st_nxt.obs[0] = obs_in.mcu_core_wake_request; // [RULE16]
      end
      `PCG_SEL_APP_WAKE: begin
        st_nxt.obs[0] = obs_in.app_core_wake_request; // [RULE16]
      end
      `PCG_SEL_HALT: begin
        st_nxt.obs[2] = (app_core_state == core_halted_state); // [RULE13]
        st_nxt.obs[1] = (mcu_core_state == core_halted_state); // [RULE13]
        st_nxt.obs[0] = sys_unclocked; // [RULE14]
      end
      default: begin
        st_nxt.obs = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_PERIPH; i++) begin
        st_r.cfg[i] <= pcg_cfg_s'(`PCG_CFG_RST);
      end
      st_r.dbg    <= pcg_dbg_s'(`PCG_DBG_RST);
      st_r.sel    <= `PCG_SEL_RST;
      st_r.bus_en <= '0;
      st_r.ker_en <= '0;
      st_r.obs    <= 8'h00;
      st_r.hold   <= pcg_hold_s'(4'h0);
      st_r.rdata  <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata            = st_r.rdata;
  assign bus_clk_en       = st_r.bus_en;
  assign ker_clk_en       = st_r.ker_en;
  assign dbg_hold         = st_r.hold;
  assign observation_port = st_r.obs;

  // Checks on peripheral 0 clocks, debug holds, observation port and read data
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic     app_only;
  pcg_cfg_s c0;
  assign c0       = st_r.cfg[0];
  assign app_only = c0.alloc_enable_bit_app && !c0.alloc_enable_bit_mcu;

  sequence s_app_halted;
    app_core_state == core_halted_state && app_only;
  endsequence

  sequence s_keep_write;
    wr_stb && addr == `PCG_ADDR_DBGCTL && wdata[`PCG_DBG_HALT_BIT];
  endsequence

  sequence s_halt_steady;
    !wr_stb && !reset && sys_halt;
  endsequence

  chk_run_clocks: assert property ( // [RULE1]
    app_core_state == core_run_state && c0.alloc_enable_bit_app
    |=> bus_clk_en[0] && ker_clk_en[0])
    else $error("Running owner lost a peripheral clock");

  chk_sleep_follows_lp: assert property ( // [RULE2]
    app_core_state == core_sleep_state && app_only
    |=> bus_clk_en[0] == $past(c0.lowpower_clock_enable_bit) &&
        ker_clk_en[0] == $past(c0.lowpower_clock_enable_bit))
    else $error("Sleep clocks do not follow low-power enable");

  chk_halt_bus_req: assert property ( // [RULE3]
    s_app_halted and (sys_mode == system_halt_level2)
    |=> bus_clk_en[0] == $past(c0.lowpower_clock_enable_bit && bus_clk_req[0]))
    else $error("Bus clock wrong in light halt mode");

  chk_lowvolt_bus: assert property ( // [RULE4]
    s_app_halted and (sys_mode == system_lowvolt_halt_level1)
    |=> bus_clk_en[0] == $past(c0.lowpower_clock_enable_bit &&
                               c0.autonomous_enable_bit && bus_clk_req[0]))
    else $error("Bus clock wrong in low-voltage halt mode");

  chk_ker_fast_src: assert property ( // [RULE5]
    s_app_halted and (c0.lowpower_clock_enable_bit && !c0.autonomous_enable_bit &&
                      c0.ksrc == fast_external_kernel_clock)
    |=> ker_clk_en[0] == $past(ker_clk_req[0]))
    else $error("Kernel clock does not follow request on fast source");

  chk_ker_slow_src: assert property ( // [RULE6]
    s_app_halted and (c0.lowpower_clock_enable_bit && !ker_clk_req[0] &&
                      c0.ksrc == slow_internal_clock)
    |=> ker_clk_en[0])
    else $error("Slow source kernel clock missing");

  chk_ker_auto: assert property ( // [RULE7]
    s_app_halted and (c0.lowpower_clock_enable_bit && c0.autonomous_enable_bit &&
                      ker_clk_req[0] && c0.ksrc == multispeed_internal_kernel_clock)
    |=> ker_clk_en[0])
    else $error("Autonomous kernel request not served");

  chk_unowned_off: assert property ( // [RULE17]
    !c0.alloc_enable_bit_app && !c0.alloc_enable_bit_mcu
    |=> !bus_clk_en[0] && !ker_clk_en[0])
    else $error("Unallocated peripheral is clocked");

  chk_other_src_off: assert property ( // [RULE19]
    s_app_halted and (c0.ksrc == other_kernel_clock)
    |=> !ker_clk_en[0])
    else $error("Kernel clock on from an unlisted source");

  chk_debug_unreach: assert property ( // [RULE9]
    sys_standby && !st_r.dbg.debug_keep_standby
    |=> !dbg_hold.debug_reachable && !dbg_hold.core_pwr_hold)
    else $error("Debug reachable in unkept standby");

  chk_keep_halt_hold: assert property ( // [RULE11]
    s_keep_write ##1 s_halt_steady [*2]
    |=> dbg_hold.sys_clk_hold && dbg_hold.debug_reachable && !observation_port[0] ||
        st_r.sel != `PCG_SEL_HALT && dbg_hold.sys_clk_hold)
    else $error("Kept halt did not hold the system clock");

  chk_obs_wait_irq: assert property ( // [RULE12]
    st_r.sel == `PCG_SEL_WAIT_IRQ
    |=> observation_port[7] == $past(obs_in.core0_wait_irq_flag) &&
        observation_port[0] == $past(obs_in.sys_wake))
    else $error("Selector 0 lines wrong");

  chk_obs_halt_lines: assert property ( // [RULE13]
    st_r.sel == `PCG_SEL_HALT
    |=> observation_port[2:0] == $past({app_core_state == core_halted_state,
                                        mcu_core_state == core_halted_state,
                                        sys_unclocked}))
    else $error("Selector 6 lines wrong");

  chk_obs_app_wake: assert property ( // [RULE16]
    st_r.sel == `PCG_SEL_APP_WAKE
    |=> observation_port == {7'h00, $past(obs_in.app_core_wake_request)})
    else $error("Selector 2 line wrong");

  chk_read_timing: assert property (
    rd_stb && addr == `PCG_ADDR_OBSSEL
    |=> rdata == 32'($past(st_r.sel)))
    else $error("Selector read back wrong");

  chk_mcu_run_clocks: assert property ( // [RULE1]
    mcu_core_state == core_run_state && c0.alloc_enable_bit_mcu
    |=> bus_clk_en[0] && ker_clk_en[0])
    else $error("Running mcu owner lost a peripheral clock");

  chk_halt_no_lp: assert property ( // [RULE19]
    s_app_halted and (!c0.lowpower_clock_enable_bit)
    |=> !bus_clk_en[0] && !ker_clk_en[0])
    else $error("Halted owner clocks without low-power enable");

  chk_deep_no_auto: assert property ( // [RULE18]
    s_app_halted and (sys_mode == system_standby_level1 && !c0.autonomous_enable_bit)
    |=> !bus_clk_en[0])
    else $error("Deep mode passed a non-autonomous bus request");

  chk_obs_wait_event: assert property ( // [RULE12] [RULE16]
    st_r.sel == `PCG_SEL_WAIT_EVENT
    |=> observation_port == {$past(obs_in.core0_wait_event_flag), 6'h00,
                             $past(obs_in.mcu_core_wake_request)})
    else $error("Selector 1 lines wrong");

  chk_obs_unused_sel: assert property (
    !(st_r.sel inside {`PCG_SEL_WAIT_IRQ, `PCG_SEL_WAIT_EVENT,
                       `PCG_SEL_APP_WAKE, `PCG_SEL_HALT})
    |=> observation_port == 8'h00)
    else $error("Unused selector drives the port");

  chk_sleep_hold: assert property ( // [RULE11]
    st_r.dbg.debug_keep_sleep && app_core_state == core_sleep_state
    |=> dbg_hold.core_clk_hold)
    else $error("Kept sleep did not hold the core clock");

  chk_standby_kept: assert property ( // [RULE10]
    sys_standby && st_r.dbg.debug_keep_standby
    |=> dbg_hold.core_pwr_hold && dbg_hold.debug_reachable)
    else $error("Kept standby lost power or debug access");

  chk_halt_unclocked: assert property ( // [RULE9]
    sys_halt && !st_r.dbg.debug_keep_halt
    |=> !dbg_hold.debug_reachable && !dbg_hold.sys_clk_hold)
    else $error("Debug reachable in unkept halt");

  chk_rdata_idle: assert property (
    !rd_stb |=> rdata == 32'h0000_0000)
    else $error("Read data not zero outside a read");

endmodule // pcg_top

// >>> hw/pcg_defines.svh
// Register offsets, field positions, reset values and selector codes
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH

`define PCG_ADDR_W          8
`define PCG_ADDR_CFG0       8'h00
`define PCG_ADDR_DBGCTL     8'h40
`define PCG_ADDR_OBSSEL     8'h44
`define PCG_ADDR_CLKSTAT    8'h48
`define PCG_ADDR_MODESTAT   8'h4C

`define PCG_CFG_W           7
`define PCG_CFG_ALLOC_APP   0
`define PCG_CFG_ALLOC_MCU   1
`define PCG_CFG_LP          2
`define PCG_CFG_AM          3
`define PCG_CFG_KSRC_LO     4

`define PCG_DBG_W           3
`define PCG_DEBUG_KEEP_SLEEP_BIT   0
`define PCG_DBG_HALT_BIT    1
`define PCG_DEBUG_KEEP_STANDBY_BIT 2

`define PCG_SEL_W           4

`define PCG_CFG_RST         7'h00
`define PCG_DBG_RST         3'h0
`define PCG_SEL_RST         4'h0

`define PCG_SEL_WAIT_IRQ    4'h0
`define PCG_SEL_WAIT_EVENT  4'h1
`define PCG_SEL_APP_WAKE    4'h2
`define PCG_SEL_HALT        4'h6

`endif

// >>> hw/pcg_pkg.sv
// Types shared by the peripheral clock gating block
package pcg_pkg;

  typedef enum logic [1:0] {
    core_run_state    = 2'h0,
    core_sleep_state  = 2'h1,
    core_halted_state = 2'h2
  } pcg_core_e;

  typedef enum logic [2:0] {
    system_run_mode             = 3'h0,
    system_halt_level1          = 3'h1,
    system_halt_level2          = 3'h2,
    system_lowpower_halt_level1 = 3'h3,
    system_lowpower_halt_level2 = 3'h4,
    system_lowvolt_halt_level1  = 3'h5,
    system_lowvolt_halt_level2  = 3'h6,
    system_standby_level1       = 3'h7
  } pcg_sys_e;

  typedef enum logic [2:0] {
    fast_internal_kernel_clock       = 3'h0,
    multispeed_internal_kernel_clock = 3'h1,
    fast_external_kernel_clock       = 3'h2,
    slow_external_clock              = 3'h3,
    slow_internal_clock              = 3'h4,
    other_kernel_clock               = 3'h5
  } pcg_ksrc_e;

  typedef struct packed {
    pcg_ksrc_e ksrc;
    logic      autonomous_enable_bit;
    logic      lowpower_clock_enable_bit;
    logic      alloc_enable_bit_mcu;
    logic      alloc_enable_bit_app;
  } pcg_cfg_s;

  typedef struct packed {
    logic debug_keep_standby;
    logic debug_keep_halt;
    logic debug_keep_sleep;
  } pcg_dbg_s;

  typedef struct packed {
    logic core0_wait_irq_flag;
    logic core0_wait_event_flag;
    logic sys_wake;
    logic app_core_wake_request;
    logic mcu_core_wake_request;
  } pcg_obs_in_s;

  typedef struct packed {
    logic core_clk_hold;
    logic sys_clk_hold;
    logic core_pwr_hold;
    logic debug_reachable;
  } pcg_hold_s;

  function automatic logic pcg_sys_halted(pcg_sys_e m);
    return (m != system_run_mode) && (m != system_standby_level1);
  endfunction

endpackage

// >>> hw/pcg_gate_cell.sv
// Clock decision for one peripheral as seen from one owning processor
module pcg_gate_cell import pcg_pkg::*; (
  // Owner and system state
  input  wire pcg_core_e core_state,
  input  wire pcg_sys_e  sys_mode,
  // Peripheral settings
  input  wire pcg_cfg_s  cfg,
  input  wire logic      alloc,
  // Peripheral requests
  input  wire logic      bus_clk_req,
  input  wire logic      ker_clk_req,
  // Decision
  output logic           bus_on,
  output logic           ker_on
);

  logic lp;
  logic am;
  logic sys_plain;
  logic sys_deep;
  logic src_fast;
  logic src_slow;
  logic src_auto;

  assign lp        = cfg.lowpower_clock_enable_bit;
  assign am        = cfg.autonomous_enable_bit;
  // Deep modes pass a bus request only for autonomous peripherals
  assign sys_deep  = (sys_mode == system_lowvolt_halt_level1) ||
                     (sys_mode == system_lowvolt_halt_level2) ||
                     (sys_mode == system_standby_level1); // [RULE18]
  assign sys_plain = !sys_deep;
  assign src_fast  = (cfg.ksrc == fast_internal_kernel_clock) ||
                     (cfg.ksrc == multispeed_internal_kernel_clock) ||
                     (cfg.ksrc == fast_external_kernel_clock);
  assign src_slow  = (cfg.ksrc == slow_external_clock) ||
                     (cfg.ksrc == slow_internal_clock);
  assign src_auto  = src_slow || (cfg.ksrc == multispeed_internal_kernel_clock);

  always_comb begin
    bus_on = 1'b0; // [RULE19]
    ker_on = 1'b0; // [RULE19]
    if (alloc) begin // [RULE17]
      case (core_state)
        core_run_state: begin
          bus_on = 1'b1; // [RULE1]
          ker_on = 1'b1; // [RULE1]
        end
        core_sleep_state: begin
          bus_on = lp; // [RULE2]
          ker_on = lp; // [RULE2]
        end
        core_halted_state: begin
          bus_on = lp && bus_clk_req && (sys_plain || am); // [RULE3] [RULE4]
          ker_on = (lp && ker_clk_req && src_fast) || // [RULE5]
                   (lp && src_slow) || // [RULE6]
                   (lp && am && ker_clk_req && src_auto); // [RULE7]
        end
        default: begin
          bus_on = 1'b0;
          ker_on = 1'b0;
        end
      endcase
    end
  end

endmodule // pcg_gate_cell

// >>> tb/pcg_periph_model.sv
// Peripheral-side model that raises bus and kernel clock requests
module pcg_periph_model #(
  parameter int       N           = 4,
  parameter bit [7:0] SERIAL_MASK = 8'h05
) (
  // Clock
  input  wire logic         clk,
  // Wishes from the bench
  input  wire logic [N-1:0] want_bus,
  input  wire logic [N-1:0] want_ker,
  // Requests to the gating block
  output logic      [N-1:0] bus_clk_req,
  output logic      [N-1:0] ker_clk_req
);
  timeunit 1ns;
  timeprecision 1ns;

  // Requests move only on the rising edge, like real peripheral logic
  always @(posedge clk) begin
    bus_clk_req <= want_bus;
    // Lanes outside the serial mask never ask for a kernel clock, whatever the bench wishes
    ker_clk_req <= want_ker & SERIAL_MASK[N-1:0];
  end
endmodule // pcg_periph_model

// >>> tb/tb_pcg_top.sv
// Self-checking random bench for the peripheral clock gating block
module tb_pcg_top import pcg_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 4;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic [7:0]        addr = 8'h00;
  logic [31:0]       wdata = 32'h0;
  logic              wr_stb = 1'b0;
  logic              rd_stb = 1'b0;
  logic [31:0]       rdata;
  pcg_core_e         app_st = core_run_state;
  pcg_core_e         mcu_st = core_run_state;
  pcg_sys_e          mode = system_run_mode;
  logic [N-1:0]      want_bus = '0;
  logic [N-1:0]      want_ker = '0;
  logic [N-1:0]      bus_req;
  logic [N-1:0]      ker_req;
  logic [N-1:0]      bus_en;
  logic [N-1:0]      ker_en;
  pcg_obs_in_s       obs = '0;
  pcg_hold_s         hold;
  logic [7:0]        obs_port;
  logic [N-1:0][6:0] cfg = '0;
  logic [2:0]        dbg = 3'h0;
  logic [3:0]        sel = 4'h0;
  int                seed = 5;
  int                failures = 0;
  int                cmp_count = 0;

  always #50 clk = ~clk;

  pcg_top #(.NUM_PERIPH(N)) pcg_top_inst (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .app_core_state(app_st), .mcu_core_state(mcu_st),
    .sys_mode(mode), .bus_clk_req(bus_req), .ker_clk_req(ker_req), .bus_clk_en(bus_en),
    .ker_clk_en(ker_en), .obs_in(obs), .dbg_hold(hold), .observation_port(obs_port)
  );

  pcg_periph_model #(.N(N)) pcg_periph_model_inst (
    .clk(clk), .want_bus(want_bus), .want_ker(want_ker),
    .bus_clk_req(bus_req), .ker_clk_req(ker_req)
  );

  // Decision of one owner: {bus, kernel}
  function automatic logic [1:0] owner(input logic [1:0] st, input logic [2:0] m,
                                       input logic [6:0] c, input logic own,
                                       input logic br, input logic kr);
    logic slow;
    logic bus;
    logic ker;
    slow = (c[6:4] == 3'h3) || (c[6:4] == 3'h4);
    if (!own) return 2'b00;
    if (st == 2'h0) return 2'b11;
    if (st == 2'h1) return {c[2], c[2]};
    if (st != 2'h2) return 2'b00;
    bus = c[2] & br & ((m < 3'h5) | c[3]);
    ker = c[2] & ((kr & (c[6:4] < 3'h3)) | slow
          | (c[3] & kr & (slow | (c[6:4] == 3'h1))));
    return {bus, ker};
  endfunction

  // Expected {hold, observation port}
  function automatic logic [11:0] exp_obs();
    logic halt;
    logic stby;
    logic [3:0] h;
    logic [7:0] p;
    halt = (mode != system_run_mode) && (mode != system_standby_level1);
    stby = (mode == system_standby_level1);
    h[3] = (dbg[0] & ((app_st == core_sleep_state) | (mcu_st == core_sleep_state)))
         | (dbg[1] & ((app_st == core_halted_state) | (mcu_st == core_halted_state)));
    h[2] = dbg[1] & halt;
    h[1] = dbg[2] & stby;
    h[0] = !(stby & !dbg[2]) & !(halt & !dbg[1]);
    case (sel)
      4'h0: p = {obs.core0_wait_irq_flag, 6'h00, obs.sys_wake};
      4'h1: p = {obs.core0_wait_event_flag, 6'h00, obs.mcu_core_wake_request};
      4'h2: p = {7'h00, obs.app_core_wake_request};
      4'h6: p = {5'h00, app_st == core_halted_state, mcu_st == core_halted_state,
                 halt & !dbg[1]};
      default: p = 8'h00;
    endcase
    return {h, p};
  endfunction

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // Read data stands one cycle only, then the port returns to zero
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    check_val(what, exp, rdata);
    @(negedge clk);
    check_val("rdata idle", 32'h0, rdata);
  endtask

  task automatic one_case(input logic [N-1:0][6:0] c, input logic [2:0] d, input logic [3:0] s,
                          input logic [1:0] a, input logic [1:0] mc, input logic [2:0] md,
                          input logic [N-1:0] wb, input logic [N-1:0] wk,
                          input pcg_obs_in_s ob, input string name);
    logic [N-1:0] eb;
    logic [N-1:0] ek;
    logic [1:0] ra;
    logic [1:0] rm;
    logic [11:0] e;
    cfg = c;
    dbg = d;
    sel = s;
    for (int i = 0; i < N; i++) bus_wr(8'(4 * i), {25'h0, c[i]});
    // Keep bits go last so a kept halt is followed by quiet bus cycles
    bus_wr(8'h44, {28'h0, s});
    bus_wr(8'h40, {29'h0, d});
    @(posedge clk);
    app_st <= pcg_core_e'(a);
    mcu_st <= pcg_core_e'(mc);
    mode <= pcg_sys_e'(md);
    want_bus <= wb;
    want_ker <= wk;
    obs <= ob;
    // Request path through the model adds one cycle to the gating latency
    repeat (3) @(posedge clk);
    @(negedge clk);
    for (int i = 0; i < N; i++) begin
      ra = owner(app_st, mode, cfg[i], cfg[i][0], bus_req[i], ker_req[i]);
      rm = owner(mcu_st, mode, cfg[i], cfg[i][1], bus_req[i], ker_req[i]);
      eb[i] = ra[1] | rm[1];
      ek[i] = ra[0] | rm[0];
    end
    e = exp_obs();
    check_val("bus_clk_en", 32'(eb), 32'(bus_en));
    check_val("ker_clk_en", 32'(ek), 32'(ker_en));
    check_val("dbg_hold", 32'(e[11:8]), 32'(hold));
    check_val("obs_port", 32'(e[7:0]), 32'(obs_port));
    bus_rd(8'h48, (32'(ek) << 8) | 32'(eb), "clock status");
    bus_rd(8'h4C, {24'h0, e[8], mode, mcu_st, app_st}, "mode status");
    bus_rd(8'h04, {25'h0, cfg[1]}, "cfg1 readback");
    $display("test %s done", name);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if ((failures == 0) && (cmp_count > 0)) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    logic [N-1:0][6:0] rc;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check_val("enables after reset", 32'h0, 32'({bus_en, ker_en}));
    bus_rd(8'h00, 32'h0, "cfg0 reset");
    bus_rd(8'h44, 32'h0, "selector reset");
    $display("test reset done");
    // Hand-made corners: deep mode without autonomy, autonomous standby, idle owner
    one_case({N{7'h35}}, 3'h0, 4'h6, 2'h2, 2'h0, 3'h5, '1, '0, 5'h00, "slow halted");
    // Kept halt entered from a halt mode, fast source on request, selector 2
    one_case({N{7'h25}}, 3'h2, 4'h2, 2'h2, 2'h0, 3'h2, '1, '1, 5'h02, "light halt fast");
    one_case({N{7'h1D}}, 3'h7, 4'h0, 2'h2, 2'h2, 3'h7, '1, '1, 5'h1F, "auto standby");
    one_case({N{7'h02}}, 3'h1, 4'h1, 2'h0, 2'h1, 3'h0, '0, '0, 5'h15, "mcu sleeping");
    // Unkept standby, unlisted source, unused selector, kept sleep
    one_case({N{7'h45}}, 3'h0, 4'h6, 2'h2, 2'h2, 3'h7, '1, '0, 5'h00, "slow int standby");
    one_case({N{7'h55}}, 3'h1, 4'hA, 2'h2, 2'h1, 3'h4, '1, '1, 5'h08, "other source");
    one_case({N{7'h05}}, 3'h5, 4'h0, 2'h1, 2'h2, 3'h6, '1, '0, 5'h11, "app sleeping");
    // Read-only and unmapped places must ignore writes
    bus_wr(8'h48, 32'hFFFF_FFFF);
    bus_wr(8'h80, 32'hFFFF_FFFF);
    bus_rd(8'h80, 32'h0, "unmapped read");
    for (int t = 0; t < 60; t++) begin
      for (int i = 0; i < N; i++) rc[i] = {3'($unsigned($random(seed)) % 6), 4'($random(seed))};
      one_case(rc, 3'($random(seed)), 4'($random(seed)), 2'($random(seed)),
               2'($random(seed)), 3'($random(seed)), N'($random(seed)), N'($random(seed)),
               pcg_obs_in_s'(5'($random(seed))), "random");
    end
    give_verdict();
  end
endmodule // tb_pcg_top
